// File: shared/irq_pkg.sv
// Purpose: constants and types shared by the interrupt controller and its CPU-side end
// Assumes: one 50 MHz clock, synchronous active-high reset
// Notes:   source numbers follow the fixed vector table
package irq_pkg;
    localparam int NUM_SRC    = 18;
    localparam int NUM_GRP    = 6;
    localparam int PRIO_LVLS  = 4;
    localparam int EVT_W      = 8;
    localparam logic [7:0] VEC_BASE = 8'h03;
    localparam logic [7:0] VEC_STEP = 8'h08;
    localparam logic [17:0] HW_CLEAR_MASK = 18'h0_1E0F;
    localparam logic [17:0] LEVEL_MASK    = 18'h0_A040;
    localparam logic [17:0] MERGED_MASK   = 18'h1_BF40;
    localparam int SRC_P2 = 6;
    localparam int SRC_WDT = 17;
    // Register addresses on the software port
    localparam logic [3:0] ADDR_CTRL    = 4'h0;
    localparam logic [3:0] ADDR_ENABLE  = 4'h1;
    localparam logic [3:0] ADDR_PRIO    = 4'h2;
    localparam logic [3:0] ADDR_STATUS  = 4'h3;
    localparam logic [3:0] ADDR_IMASK   = 4'h4;
    localparam logic [3:0] ADDR_SRCFLAG = 4'h5;
    localparam logic [3:0] ADDR_SRCMASK = 4'h6;
    localparam logic [3:0] ADDR_CLRFLAG = 4'h7;
    localparam logic [3:0] ADDR_VECTOR  = 4'h8;
    localparam logic [1:0] IRQ_EVT_ACK  = 2'd0;
    localparam logic [1:0] IRQ_EVT_RETI = 2'd1;
    localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
    typedef logic [NUM_SRC-1:0] src_vec_t;
    typedef logic [1:0]         prio_t;
    typedef enum logic [1:0] {
        CPU_IDLE = 2'b00,
        CPU_REQ  = 2'b01,
        CPU_ISR  = 2'b10
    } cpu_state_t;
endpackage

// File: shared/irq_if.sv
// Purpose: link between the interrupt controller and the CPU core end
// Assumes: both ends on the one clock
// Notes:   ack is a one-cycle pulse, reti likewise
`timescale 1ns/1ps
interface irq_if (
    input wire logic clock
);
    import irq_pkg::*;
    logic             irq_req;
    logic [7:0]       irq_vector;
    logic [4:0]       irq_src;
    prio_t            irq_level;
    logic             irq_ack;
    logic             irq_reti;
    src_vec_t         cpu_flag_clr;
    modport ctrl (
        input  clock, irq_ack, irq_reti, cpu_flag_clr,
        output irq_req, irq_vector, irq_src, irq_level
    );
    modport cpu (
        input  clock, irq_req, irq_vector, irq_src, irq_level,
        output irq_ack, irq_reti, cpu_flag_clr
    );
endinterface

// File: hw/irq_ctrl.sv
// Purpose: interrupt request flags, masking, priority and vector selection
// Assumes: peripheral events arrive as one-cycle pulses, port inputs as levels
// Notes:   software owns enables and priorities through the register port
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module irq_ctrl (
    input  wire logic                    clock,
    input  wire logic                    sys_rst,
    irq_if.ctrl                          link,
    input  wire logic [irq_pkg::NUM_SRC-1:0]              src_pulse,
    input  wire logic [irq_pkg::NUM_SRC*irq_pkg::EVT_W-1:0] src_events,
    input  wire logic                    port2_usb_i2c_request,
    input  wire logic                    wdt_overflow,
    input  wire logic                    wdt_timer_mode,
    input  wire logic [3:0]              addr,
    input  wire logic [31:0]             wdata,
    input  wire logic                    wr_stb,
    input  wire logic                    rd_stb,
    output logic      [31:0]             rdata,
    output logic                         irq_out
);
    import irq_pkg::*;

    logic                global_irq_enable;
    src_vec_t            irq_en_reg;
    logic [11:0]         prio_reg;
    src_vec_t            cpu_flag_reg;
    logic [EVT_W-1:0]    src_flag_reg [NUM_SRC];
    logic [EVT_W-1:0]    src_mask_reg [NUM_SRC];
    logic [1:0]          stat_reg;
    logic [1:0]          imask_reg;
    logic [4:0]          sel_reg;
    logic [4:0]          sel_next;
    logic                found_next;
    prio_t               lvl_next;
    prio_t               active_lvl_reg;
    logic                in_service_reg;
    prio_t               stack_reg [PRIO_LVLS];
    logic [1:0]          depth_reg;
    src_vec_t            cause;
    src_vec_t            pend;
    logic                ack;
    logic [4:0]          sel_idx_wr;

    assign ack = link.irq_ack;
    assign sel_idx_wr = wdata[12:8];

    // ==========================================================
    // Source conditions
    // ==========================================================
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : gen_src
            logic [EVT_W-1:0] ev;
            assign ev = src_events[g*EVT_W +: EVT_W];
            always_ff @(posedge clock) begin
                if (sys_rst) begin
                    src_flag_reg[g] <= '0;
                end else if (wr_stb && addr == ADDR_CLRFLAG && sel_idx_wr == 5'(g)) begin
                    src_flag_reg[g] <= (src_flag_reg[g] & wdata[EVT_W-1:0]) | ev;
                end else begin
                    src_flag_reg[g] <= src_flag_reg[g] | ev;
                end
            end
            if (g == SRC_P2) begin : gen_p2
                assign cause[g] = port2_usb_i2c_request
                    | (|(src_flag_reg[g] & src_mask_reg[g]));
            end else if (g == SRC_WDT) begin : gen_wdt
                assign cause[g] = wdt_overflow & wdt_timer_mode;
            end else if (MERGED_MASK[g]) begin : gen_merged
                assign cause[g] = |(src_flag_reg[g] & src_mask_reg[g]);
            end else begin : gen_plain
                assign cause[g] = src_pulse[g];
            end
        end
    endgenerate

    // ==========================================================
    // CPU-level flags
    // ==========================================================
    // flag per source, set always
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cpu_flag_reg <= '0;
        end else begin
            // hardware clear on entry for HW_CLEAR_MASK sources only; level sources re-assert
            cpu_flag_reg <= (cpu_flag_reg
                & ~link.cpu_flag_clr
                & ~((ack ? HW_CLEAR_MASK : '0) & src_vec_t'(1 << sel_reg)))
                | cause;
        end
    end

    // ==========================================================
    // Arbitration
    // ==========================================================
    // enable gating
    assign pend = global_irq_enable ? (cpu_flag_reg & irq_en_reg) : '0;

    always_comb begin
        found_next = 1'b0;
        sel_next   = 5'd0;
        lvl_next   = 2'd0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (pend[i] && (!found_next || prio_reg[2*(i%NUM_GRP) +: 2] >= lvl_next)) begin
                found_next = 1'b1;
                sel_next   = 5'(i);
                lvl_next   = prio_reg[2*(i%NUM_GRP) +: 2];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            link.irq_req   <= 1'b0;
            link.irq_vector <= 8'h00;
            link.irq_src   <= 5'd0;
            link.irq_level <= 2'd0;
            sel_reg        <= 5'd0;
        end else begin
            link.irq_req    <= found_next && !ack && (!in_service_reg || lvl_next > active_lvl_reg);
            // Offer held until taken, so ack clears and takes the level of the taken source
            if (!link.irq_req || ack) begin
                link.irq_vector <= VEC_BASE + VEC_STEP * {3'd0, sel_next};
                link.irq_src    <= sel_next;
                link.irq_level  <= lvl_next;
                sel_reg         <= sel_next;
            end
        end
    end

    // Nesting of active levels
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            in_service_reg <= 1'b0;
            active_lvl_reg <= 2'd0;
            depth_reg      <= 2'd0;
            for (int k = 0; k < PRIO_LVLS; k++) stack_reg[k] <= 2'd0;
        end else if (ack) begin
            stack_reg[depth_reg] <= active_lvl_reg;
            depth_reg            <= depth_reg + 2'd1;
            active_lvl_reg       <= link.irq_level;
            in_service_reg       <= 1'b1;
        end else if (link.irq_reti && in_service_reg) begin
            depth_reg      <= depth_reg - 2'd1;
            active_lvl_reg <= stack_reg[depth_reg - 2'd1];
            in_service_reg <= depth_reg != 2'd1;
        end
    end

    // ==========================================================
    // Software registers
    // ==========================================================
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            global_irq_enable <= 1'b0;
            irq_en_reg        <= '0;
            prio_reg          <= '0;
            imask_reg         <= '0;
            for (int k = 0; k < NUM_SRC; k++) src_mask_reg[k] <= '0;
        end else if (wr_stb) begin
            case (addr)
                ADDR_CTRL:    global_irq_enable <= wdata[0];
                ADDR_ENABLE:  irq_en_reg <= wdata[NUM_SRC-1:0];
                ADDR_PRIO:    prio_reg <= wdata[11:0];
                ADDR_IMASK:   imask_reg <= wdata[1:0];
                ADDR_SRCMASK: begin
                    if (sel_idx_wr < 5'(NUM_SRC)) begin
                        src_mask_reg[sel_idx_wr] <= wdata[EVT_W-1:0];
                    end
                end
                default: ;
            endcase
        end
    end

    // Sticky events: acknowledge and return; set wins over clear
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stat_reg <= '0;
        end else begin
            stat_reg <= (stat_reg & ~((wr_stb && addr == ADDR_STATUS) ? wdata[1:0] : 2'b00))
                | {link.irq_reti, ack};
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(stat_reg & imask_reg);
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdata <= RESET_WORD;
        end else if (rd_stb) begin
            unique case (addr)
                ADDR_CTRL:    rdata <= {31'd0, global_irq_enable};
                ADDR_ENABLE:  rdata <= {14'd0, irq_en_reg};
                ADDR_PRIO:    rdata <= {20'd0, prio_reg};
                ADDR_STATUS:  rdata <= {30'd0, stat_reg};
                ADDR_IMASK:   rdata <= {30'd0, imask_reg};
                ADDR_SRCFLAG: rdata <= {14'd0, cpu_flag_reg};
                ADDR_VECTOR:  rdata <= {15'd0, in_service_reg, 3'd0, sel_reg, link.irq_vector};
                default:      rdata <= RESET_WORD;
            endcase
        end else begin
            rdata <= RESET_WORD;
        end
    end
endmodule

// File: hw/irq_cpu_end.sv
// Purpose: CPU-core end: takes requests, calls vectors, returns
// Assumes: requests come straight from controller flops
// Notes:   user side starts return and flag clears
`timescale 1ns/1ps
module irq_cpu_end (
    input  wire logic                       clock,
    input  wire logic                       sys_rst,
    irq_if.cpu                              link,
    input  wire logic                       reti_req,
    input  wire logic [irq_pkg::NUM_SRC-1:0] flag_clr_req,
    output logic                            call_valid,
    output logic      [7:0]                 call_vector,
    output logic      [4:0]                 active_src
);
    import irq_pkg::*;

    cpu_state_t state_reg;
    logic [2:0] depth_reg;

    // ==========================================================
    // Acknowledge and return
    // ==========================================================
    // ack forces vector call
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg    <= CPU_IDLE;
            depth_reg    <= 3'd0;
            link.irq_ack <= 1'b0;
            link.irq_reti <= 1'b0;
            call_valid   <= 1'b0;
            call_vector  <= 8'h00;
            active_src   <= 5'd0;
        end else begin
            link.irq_ack  <= 1'b0;
            link.irq_reti <= 1'b0;
            call_valid    <= 1'b0;
            unique case (state_reg)
                CPU_IDLE, CPU_ISR: begin
                    if (link.irq_req && !link.irq_ack) begin
                        link.irq_ack <= 1'b1;
                        call_valid   <= 1'b1;
                        call_vector  <= link.irq_vector;
                        active_src   <= link.irq_src;
                        state_reg    <= CPU_ISR;
                        depth_reg    <= depth_reg + 3'd1;
                    end else if (reti_req && state_reg == CPU_ISR) begin
                        link.irq_reti <= 1'b1;
                        depth_reg     <= depth_reg - 3'd1;
                        state_reg     <= (depth_reg == 3'd1) ? CPU_IDLE : CPU_ISR;
                    end
                end
                CPU_REQ: state_reg <= CPU_ISR;
                default: state_reg <= CPU_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            link.cpu_flag_clr <= '0;
        end else begin
            link.cpu_flag_clr <= flag_clr_req;
        end
    end
endmodule

// File: testbench/irq_link_asserts.sv
// Purpose: timing checks on the controller to CPU-end link
// Assumes: one clock, synchronous active-high reset
// Notes:   sees only the interface signals
`timescale 1ns/1ps
module irq_link_asserts
    import irq_pkg::*;
(
    input wire logic       clock,
    input wire logic       sys_rst,
    input wire logic       irq_req,
    input wire logic [7:0] irq_vector,
    input wire logic [4:0] irq_src,
    input wire prio_t      irq_level,
    input wire logic       irq_ack,
    input wire logic       irq_reti,
    input wire src_vec_t   cpu_flag_clr
);
    // ==========================================
    // Level of the service last taken, dropped on any return
    logic  svc_valid_reg;
    prio_t svc_level_reg;
    always_ff @(posedge clock) begin
        if (sys_rst || irq_reti) begin
            svc_valid_reg <= 1'b0;
        end else if (irq_ack) begin
            svc_valid_reg <= 1'b1;
        end
    end
    always_ff @(posedge clock) begin
        if (irq_ack) begin
            svc_level_reg <= irq_level;
        end
    end
    // ==========================================
    // Properties
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence s_take; irq_req && !irq_ack; endsequence
    sequence s_answer; irq_ack ##1 (!irq_ack && !irq_req); endsequence
    property p_vector; irq_req |-> irq_vector == VEC_BASE + {irq_src, 3'b000}; endproperty
    property p_src_range; irq_req |-> irq_src < 5'h12; endproperty
    property p_handshake; $rose(irq_req) |=> s_answer; endproperty
    property p_ack_cause; irq_ack |-> $past(irq_req) && !$past(irq_ack); endproperty
    property p_ack_pulse; irq_ack |=> !irq_ack; endproperty
    property p_req_release; irq_ack |=> !irq_req; endproperty
    property p_req_hold; s_take |=> irq_req; endproperty
    property p_preempt; irq_ack && svc_valid_reg |-> irq_level > svc_level_reg; endproperty
    a_vector: assert property (p_vector) else $error("vector not base plus eight per source");
    a_src_range: assert property (p_src_range) else $error("source number out of range");
    a_handshake: assert property (p_handshake) else $error("request not acked next cycle");
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_req_release: assert property (p_req_release) else $error("request held after ack");
    a_req_hold: assert property (p_req_hold) else $error("request dropped before ack");
    a_preempt: assert property (p_preempt) else $error("preempted by lower or equal level");
endmodule

// File: testbench/tb.sv
// Purpose: self-checking bench for controller and CPU end together
// Assumes: 50 MHz clock, synchronous active-high reset
// Notes:   interrupt mask bit set means the event reaches irq_out
`timescale 1ns/1ps
module tb;
    import irq_pkg::*;
    logic                     clock;
    logic                     sys_rst;
    src_vec_t                 src_pulse;
    logic [NUM_SRC*EVT_W-1:0] src_events;
    logic                     port2_usb_i2c_request;
    logic                     wdt_overflow;
    logic                     wdt_timer_mode;
    logic [3:0]               addr;
    logic [31:0]              wdata;
    logic                     wr_stb;
    logic                     rd_stb;
    logic [31:0]              rdata;
    logic                     irq_out;
    logic                     reti_req;
    src_vec_t                 flag_clr_req;
    logic                     call_valid;
    logic [7:0]               call_vector;
    logic [4:0]               active_src;
    logic [31:0]              f;
    int                       n_fail;
    int                       checks;
    irq_if irq_if_inst (.clock(clock));
    irq_ctrl irq_ctrl_inst (.clock(clock), .sys_rst(sys_rst), .link(irq_if_inst),
        .src_pulse(src_pulse), .src_events(src_events),
        .port2_usb_i2c_request(port2_usb_i2c_request), .wdt_overflow(wdt_overflow),
        .wdt_timer_mode(wdt_timer_mode), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .irq_out(irq_out));
    irq_cpu_end irq_cpu_end_inst (.clock(clock), .sys_rst(sys_rst), .link(irq_if_inst),
        .reti_req(reti_req), .flag_clr_req(flag_clr_req), .call_valid(call_valid),
        .call_vector(call_vector), .active_src(active_src));
    irq_link_asserts irq_link_asserts_inst (.clock(clock), .sys_rst(sys_rst),
        .irq_req(irq_if_inst.irq_req), .irq_vector(irq_if_inst.irq_vector),
        .irq_src(irq_if_inst.irq_src), .irq_level(irq_if_inst.irq_level),
        .irq_ack(irq_if_inst.irq_ack), .irq_reti(irq_if_inst.irq_reti),
        .cpu_flag_clr(irq_if_inst.cpu_flag_clr));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // ==========================================
    // Shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (n_fail == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        @(negedge clock);
        f = rdata;
    endtask
    task automatic pulse(input src_vec_t m);
        @(posedge clock);
        src_pulse <= m;
        @(posedge clock);
        src_pulse <= '0;
    endtask
    task automatic clr(input src_vec_t m);
        @(posedge clock);
        flag_clr_req <= m;
        @(posedge clock);
        flag_clr_req <= '0;
    endtask
    task automatic reti();
        @(posedge clock);
        reti_req <= 1'b1;
        @(posedge clock);
        reti_req <= 1'b0;
    endtask
    task automatic wait_call(input int n);
        int i;
        for (i = 0; i < 40; i++) begin
            @(negedge clock);
            if (call_valid === 1'b1) break;
        end
        if (i == 40) begin
            n_fail++;
            complete_run();
        end else begin
            chk(32'(call_vector), 32'h0000_0003 + 8 * n);
            chk(32'(active_src), n);
        end
        @(posedge clock);
    endtask
    task automatic no_call(input int k);
        logic seen;
        seen = 1'b0;
        repeat (k) begin
            @(negedge clock);
            seen = seen | call_valid;
        end
        chk(32'(seen), 32'h0000_0000);
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reset();
        logic [3:0] regs [5] = '{ADDR_CTRL, ADDR_ENABLE, ADDR_PRIO, ADDR_IMASK, 4'hF};
        foreach (regs[k]) begin
            rd(regs[k]);
            chk(f, RESET_WORD);
        end
    endtask
    task automatic t_gate();
        wr(ADDR_IMASK, 32'h0000_0001);
        pulse(18'h0_0010);
        rd(ADDR_SRCFLAG);
        chk(32'(f[4]), 32'h0000_0001);
        wr(ADDR_ENABLE, 32'h0003_FFFF);
        no_call(8);
        chk(32'(irq_out), 32'h0000_0000);
        wr(ADDR_CTRL, 32'h0000_0001);
        wait_call(4);
        // Ack event reaches irq_out two flops later
        repeat (2) @(negedge clock);
        chk(32'(irq_out), 32'h0000_0001);
        wr(ADDR_STATUS, 32'h0000_0001);
        rd(ADDR_SRCFLAG);
        chk(32'(f[4]), 32'h0000_0001);
        chk(32'(irq_out), 32'h0000_0000);
        clr(18'h0_0010);
        reti();
        no_call(4);
        chk(32'(irq_out), 32'h0000_0000);
    endtask
    task automatic t_sweep();
        int plain [7] = '{0, 1, 2, 3, 5, 7, 14};
        foreach (plain[k]) begin
            wr(ADDR_ENABLE, 32'h0000_0001 << plain[k]);
            pulse(18'h0_0001 << plain[k]);
            wait_call(plain[k]);
            rd(ADDR_SRCFLAG);
            chk(32'(f[plain[k]]), 32'(plain[k] > 3));
            clr(18'h0_0001 << plain[k]);
            reti();
        end
    endtask
    task automatic t_prio();
        wr(ADDR_ENABLE, 32'h0003_FFFF);
        pulse(18'h0_0024);
        wait_call(2);
        wr(ADDR_PRIO, 32'h0000_0C00);
        wait_call(5);
        clr(18'h0_0020);
        pulse(18'h0_0002);
        no_call(8);
        reti();
        no_call(4);
        reti();
        wait_call(1);
        reti();
        wr(ADDR_PRIO, 32'h0000_0000);
    endtask
    task automatic t_level();
        wr(ADDR_ENABLE, 32'h0000_0040);
        port2_usb_i2c_request <= 1'b1;
        wait_call(6);
        clr(18'h0_0040);
        rd(ADDR_SRCFLAG);
        chk(32'(f[6]), 32'h0000_0001);
        @(posedge clock);
        port2_usb_i2c_request <= 1'b0;
        clr(18'h0_0040);
        rd(ADDR_SRCFLAG);
        chk(32'(f[6]), 32'h0000_0000);
        reti();
    endtask
    task automatic t_wdt_events();
        wr(ADDR_ENABLE, 32'h0000_0000);
        for (int m = 0; m < 2; m++) begin
            @(posedge clock);
            wdt_timer_mode <= m[0];
            wdt_overflow <= 1'b1;
            @(posedge clock);
            wdt_overflow <= 1'b0;
            rd(ADDR_SRCFLAG);
            chk(32'(f[17]), 32'(m));
            wr(ADDR_SRCMASK, 32'h0000_08FE);
            @(posedge clock);
            src_events[8 * EVT_W + m] <= 1'b1;
            @(posedge clock);
            src_events <= '0;
            rd(ADDR_SRCFLAG);
            chk(32'(f[8]), 32'(m));
        end
        no_call(4);
        // Clear event bit 1 of source 8, keep the rest
        wr(ADDR_CLRFLAG, 32'h0000_08FD);
        clr(18'h0_0100);
        rd(ADDR_SRCFLAG);
        chk(32'(f[8]), 32'h0000_0000);
        wr(ADDR_SRCMASK, 32'h0000_0801);
        rd(ADDR_SRCFLAG);
        chk(32'(f[8]), 32'h0000_0001);
    endtask
    initial begin
        n_fail = 0;
        checks = 0;
        sys_rst = 1'b1;
        src_pulse = '0;
        src_events = '0;
        port2_usb_i2c_request = 1'b0;
        wdt_overflow = 1'b0;
        wdt_timer_mode = 1'b0;
        addr = 4'h0;
        wdata = 32'h0000_0000;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        reti_req = 1'b0;
        flag_clr_req = '0;
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        t_reset();
        t_gate();
        t_sweep();
        t_prio();
        t_level();
        t_wdt_events();
        complete_run();
    end
endmodule
